/* src/scale_weight_processor.sv */
/*
 weight processor: filter, motion, zero handling, tare and net weight.
 assumes sample_valid pulses 300 times per second; commands are one-cycle pulses.
*/
// Contract
// - net equals gross minus tare in use; net shown after a tare
// - accepted tare captures present gross into auto tare
// - auto-only mode uses auto tare and refuses preset writes
// - preset-only uses preset; combined uses auto plus preset
// - preset tare written by master when the mode permits preset
// - with stability gating, tare refused during motion
// - unipolar overload check refuses tare at negative gross
// - gross/net toggles display; net refused when tare in use is zero
// - accepted zero re-zeros gross and clears auto tare
// - zero only without motion and within plus/minus ten percent capacity
// - good zero when magnitude below a quarter resolution step
// - tracking and auto-zero need zero in range and no setpoint armed
// - tracking needs mode on, good zero, no motion, rate under limit
// - tracking limit is per minute, scaled with the resolution
// - auto-zero needs mode, negative gross, gross shown, stable five seconds
// - motion when change over 100 ms exceeds motion window
// - motion held for no-motion delay after weight settles
// - motion blocks zeroing; gated print waits for stability
// - bandwidth selectable from 0.125 Hz to 50 Hz
// - three lowest settings jump to 1 Hz on large 100 ms change
// - step response settles within listed rise time per setting
// - one weight value per sample, 300 per second, paces motion, tracking and auto-zero checks
`timescale 1ns/1ps
`include "scale_weight_regs.svh"
module scale_weight_processor (
    input  wire logic                         clk_sys,
    input  wire logic                         rstn,
    input  wire logic                         sample_valid,
    input  wire logic signed [`WEIGHT_W-1:0]  raw_weight,
    input  wire scale_weight_pkg::cmd_t       cmd,
    input  wire logic signed [`WEIGHT_W-1:0]  preset_value,
    input  wire logic                         print_req,
    input  wire scale_weight_pkg::tare_mode_t tare_mode,
    input  wire scale_weight_pkg::track_mode_t track_mode,
    input  wire logic                         motion_check,
    input  wire logic                         unipolar,
    input  wire logic                         setpoint_armed,
    input  wire logic [3:0]                   bandwidth,
    input  wire logic [`WEIGHT_W-1:0]         capacity,
    input  wire logic [`WEIGHT_W-1:0]         resolution,
    input  wire logic [`WEIGHT_W-1:0]         motion_window,
    input  wire logic [`WEIGHT_W-1:0]         filter_window,
    input  wire logic [15:0]                  no_motion_delay,
    input  wire logic [7:0]                   track_rate_steps,
    output logic signed [`WEIGHT_W-1:0]       gross_out,
    output logic signed [`WEIGHT_W-1:0]       net_out,
    output logic signed [`WEIGHT_W-1:0]       display_out,
    output logic signed [`WEIGHT_W-1:0]       auto_tare,
    output logic signed [`WEIGHT_W-1:0]       preset_tare,
    output scale_weight_pkg::status_t         status,
    output logic                              print_go,
    output logic                              weight_valid
);
    localparam int W = `WEIGHT_W;
    localparam int PER = `MOTION_PERIOD_SMP;
    localparam int AZ = `AUTOZERO_SMP;
    localparam int PMIN = `SMP_PER_MIN;

    // filter shift per bandwidth code 0=50 Hz .. 9=0.125 Hz (one-pole, k doubles)
    function automatic logic [3:0] bw_shift(input logic [3:0] b);
        bw_shift = (b > 4'h9) ? 4'hB : 4'(b + 4'h2);
    endfunction

    logic signed [W+15:0] filt_q, filt_d;
    logic signed [W-1:0]  zero_off_q, zero_off_d;
    logic signed [W-1:0]  atare_q, atare_d, ptare_q, ptare_d;
    logic signed [W-1:0]  ref_q, ref_d, fref_q, fref_d;
    logic [6:0]           per_q, per_d;
    logic                 moving_q, moving_d, motion_q, motion_d, fast_q, fast_d;
    logic [15:0]          hold_q, hold_d;
    logic [10:0]          stable_q, stable_d;
    logic                 net_q, net_d, print_pend_q, print_pend_d, vld_q, vld_d;
    logic signed [W-1:0]  track_acc_q, track_acc_d;
    logic [14:0]          min_q, min_d;

    logic signed [W-1:0]  filt_w, gross, tare_use, dref, dfref, zlim, abs_g;
    logic                 good_zero, zero_in_range, tare_ok, zero_ok, preset_ok;
    logic [3:0]           sh;

    always_comb begin
        filt_w   = filt_q[W+15:16];
        gross    = W'(filt_w - zero_off_q);
        case (tare_mode)
            scale_weight_pkg::TARE_AUTO:   tare_use = atare_q;
            scale_weight_pkg::TARE_PRESET: tare_use = ptare_q;
            scale_weight_pkg::TARE_BOTH:   tare_use = W'(atare_q + ptare_q);
            default:                       tare_use = atare_q;
        endcase
        abs_g    = gross[W-1] ? W'(-gross) : gross;
        good_zero = ({abs_g, 2'b00} < {2'b00, resolution});
        zlim     = W'((48'(capacity) * `ZERO_RANGE_PCT) / 100);
        zero_in_range = ((zero_off_q + gross) <= zlim) &&
                        ((zero_off_q + gross) >= W'(-zlim));
        dref     = W'(filt_w - ref_q);
        dfref    = W'(W'(raw_weight) - fref_q);
        tare_ok  = !(motion_check && motion_q) && !(unipolar && gross[W-1]);
        zero_ok  = !motion_q && zero_in_range;
        preset_ok = (tare_mode != scale_weight_pkg::TARE_AUTO);
        sh       = (fast_q && bandwidth >= `BW_LOW_LIMIT) ? bw_shift(`BW_FAST_CODE)
                                                          : bw_shift(bandwidth);
    end

    always_comb begin
        filt_d       = filt_q;
        zero_off_d   = zero_off_q;
        atare_d      = atare_q;
        ptare_d      = ptare_q;
        ref_d        = ref_q;
        fref_d       = fref_q;
        per_d        = per_q;
        moving_d     = moving_q;
        motion_d     = motion_q;
        fast_d       = fast_q;
        hold_d       = hold_q;
        stable_d     = stable_q;
        net_d        = net_q;
        print_pend_d = print_pend_q;
        vld_d        = 1'b0;
        track_acc_d  = track_acc_q;
        min_d        = min_q;
        if (sample_valid) begin
            vld_d  = 1'b1;
            // concatenation is unsigned; without the cast a negative step shifts in zeros
            filt_d = filt_q + (($signed({raw_weight, 16'h0000}) - filt_q) >>> sh);
            if (per_q == 7'(PER - 1)) begin
                per_d  = 7'h00;
                ref_d  = filt_w;
                fref_d = raw_weight;
                moving_d = (dref > $signed(motion_window)) ||
                           (dref < W'(-$signed(motion_window)));
                fast_d = (dfref > $signed(filter_window)) ||
                         (dfref < W'(-$signed(filter_window)));
            end else begin
                per_d = 7'(per_q + 7'h01);
            end
            if (moving_q) begin
                motion_d = 1'b1;
                hold_d   = no_motion_delay;
            end else if (hold_q != 16'h0000) begin
                hold_d = 16'(hold_q - 16'h0001);
            end else begin
                motion_d = 1'b0;
            end
            stable_d = motion_q ? 11'h000 :
                       (stable_q == 11'(AZ) ? stable_q : 11'(stable_q + 11'h001));
            min_d = (min_q == 15'(PMIN - 1)) ? 15'h0000 : 15'(min_q + 15'h0001);
            if (min_q == 15'(PMIN - 1)) track_acc_d = '0;
            if (zero_in_range && !setpoint_armed) begin
                if (track_mode != scale_weight_pkg::TRACK_OFF && good_zero && !motion_q &&
                    (track_acc_q + abs_g) < W'(32'(track_rate_steps) * resolution)) begin
                    zero_off_d  = W'(zero_off_q + gross);
                    track_acc_d = W'(track_acc_q + abs_g);
                end else if (track_mode == scale_weight_pkg::TRACK_ON_AZ && gross[W-1] &&
                             !net_q && stable_q == 11'(AZ)) begin
                    zero_off_d = W'(zero_off_q + gross);
                end
            end
        end
        if (cmd.zero && zero_ok) begin
            zero_off_d = W'(zero_off_q + gross);
            atare_d    = '0;
            if (tare_mode == scale_weight_pkg::TARE_AUTO) net_d = 1'b0;
        end else if (cmd.tare && tare_ok) begin
            atare_d = gross;
            net_d   = 1'b1;
        end else if (cmd.gross_net) begin
            if (net_q) net_d = 1'b0;
            else if (tare_use != '0) net_d = 1'b1;
        end
        if (cmd.preset_wr && preset_ok) ptare_d = preset_value;
        if (print_req) print_pend_d = 1'b1;
        else if (print_pend_q && !(motion_check && motion_q)) print_pend_d = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            filt_q       <= '0;
            zero_off_q   <= '0;
            atare_q      <= '0;
            ptare_q      <= '0;
            ref_q        <= '0;
            fref_q       <= '0;
            per_q        <= '0;
            moving_q     <= 1'b0;
            motion_q     <= 1'b0;
            fast_q       <= 1'b0;
            hold_q       <= '0;
            stable_q     <= '0;
            net_q        <= 1'b0;
            print_pend_q <= 1'b0;
            vld_q        <= 1'b0;
            track_acc_q  <= '0;
            min_q        <= '0;
        end else begin
            filt_q       <= filt_d;
            zero_off_q   <= zero_off_d;
            atare_q      <= atare_d;
            ptare_q      <= ptare_d;
            ref_q        <= ref_d;
            fref_q       <= fref_d;
            per_q        <= per_d;
            moving_q     <= moving_d;
            motion_q     <= motion_d;
            fast_q       <= fast_d;
            hold_q       <= hold_d;
            stable_q     <= stable_d;
            net_q        <= net_d;
            print_pend_q <= print_pend_d;
            vld_q        <= vld_d;
            track_acc_q  <= track_acc_d;
            min_q        <= min_d;
        end
    end

    // outputs registered one cycle after the state they reflect
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gross_out   <= '0;
            net_out     <= '0;
            display_out <= '0;
        end else begin
            gross_out   <= gross;
            net_out     <= W'(gross - tare_use);
            display_out <= net_q ? W'(gross - tare_use) : gross;
        end
    end

    assign auto_tare        = atare_q;
    assign preset_tare      = ptare_q;
    assign weight_valid     = vld_q;
    // one driver for the whole struct
    assign status           = {motion_q, good_zero, net_q,
                               print_pend_q && !(motion_check && motion_q)};
    assign print_go         = status.print_ok;

    a_tare_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd.tare && !cmd.zero && tare_ok |=> atare_q == $past(gross))
        else $error("tare did not capture gross");
    a_tare_motion: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd.tare && motion_check && motion_q && !cmd.zero |=> $stable(atare_q))
        else $error("tare accepted during motion");
    a_tare_neg: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd.tare && unipolar && gross[W-1] && !cmd.zero |=> $stable(atare_q))
        else $error("tare accepted at negative gross");
    a_preset_lock: assert property (@(posedge clk_sys) disable iff (!rstn)
        tare_mode == scale_weight_pkg::TARE_AUTO |=> $stable(ptare_q))
        else $error("preset written in auto mode");
    a_net_refuse: assert property (@(posedge clk_sys) disable iff (!rstn)
        !net_q && cmd.gross_net && !cmd.tare && !cmd.zero && tare_use == '0 |=> !net_q)
        else $error("net shown with zero tare");
    a_zero_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd.zero && zero_ok |=> atare_q == '0)
        else $error("zero did not clear auto tare");
    a_zero_motion: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd.zero && motion_q && !sample_valid && !cmd.tare |=> $stable(zero_off_q))
        else $error("zero accepted during motion");
    a_motion_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        moving_q && sample_valid |=> motion_q)
        else $error("motion flag not raised");
    a_print_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
        motion_check && motion_q |-> !print_go)
        else $error("print released during motion");
    a_print_held: assert property (@(posedge clk_sys) disable iff (!rstn)
        print_pend_q && motion_check && motion_q |=> print_pend_q)
        else $error("pending print lost during motion");
    a_net_select: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd.tare && !cmd.zero && tare_ok |=> net_q)
        else $error("net not selected after tare");
    a_display_net: assert property (@(posedge clk_sys) disable iff (!rstn)
        net_q |=> display_out == net_out)
        else $error("display not net weight");
    a_preset_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd.preset_wr && preset_ok |=> ptare_q == $past(preset_value))
        else $error("preset value not taken");
    a_zero_apply: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd.zero && zero_ok |=> zero_off_q == $past(filt_w))
        else $error("zero did not re-zero gross");
    a_zero_range: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd.zero && !zero_in_range && !sample_valid |=> $stable(zero_off_q))
        else $error("zero accepted out of range");
    a_good_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        gross == '0 && resolution != '0 |-> status.good_zero)
        else $error("good zero missing at zero gross");
    a_track_armed: assert property (@(posedge clk_sys) disable iff (!rstn)
        setpoint_armed && !cmd.zero |=> $stable(zero_off_q))
        else $error("zero moved with setpoint armed");
    a_track_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        track_mode == scale_weight_pkg::TRACK_OFF && !cmd.zero |=> $stable(zero_off_q))
        else $error("zero moved with tracking off");
    a_hold_load: assert property (@(posedge clk_sys) disable iff (!rstn)
        moving_q && sample_valid |=> hold_q == $past(no_motion_delay))
        else $error("no-motion delay not loaded");
    a_valid_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        sample_valid |=> weight_valid)
        else $error("weight valid not raised");
endmodule // scale_weight_processor

/* src/scale_weight_regs.svh */
/*
 constants for the weight processor: timing counts, field codes, limits.
 assumes a 40 MHz system clock and a 300 per second sample strobe.
*/
`ifndef SCALE_WEIGHT_REGS_SVH
`define SCALE_WEIGHT_REGS_SVH
`define CLK_HZ            40000000
`define SAMPLE_RATE_HZ    300
`define MOTION_PERIOD_MS  100
`define MOTION_PERIOD_SMP ((`SAMPLE_RATE_HZ * `MOTION_PERIOD_MS) / 1000)
`define AUTOZERO_STABLE_S 5
`define AUTOZERO_SMP      (`SAMPLE_RATE_HZ * `AUTOZERO_STABLE_S)
`define ZERO_RANGE_PCT    10
`define SMP_PER_MIN       (`SAMPLE_RATE_HZ * 60)
`define BW_FAST_CODE      4'h6
`define BW_LOW_LIMIT      4'h7
`define BW_COUNT          10
`define WEIGHT_W          24
`endif

/* src/scale_weight_pkg.sv */
/*
 types shared by the weight processor.
 assumes the constants header is included where numbers are needed.
*/
package scale_weight_pkg;
    typedef enum logic [1:0] {TARE_AUTO, TARE_PRESET, TARE_BOTH} tare_mode_t;
    typedef enum logic [1:0] {TRACK_OFF, TRACK_ON, TRACK_ON_AZ} track_mode_t;
    typedef struct packed {
        logic tare;
        logic zero;
        logic gross_net;
        logic preset_wr;
    } cmd_t;
    typedef struct packed {
        logic motion;
        logic good_zero;
        logic net_shown;
        logic print_ok;
    } status_t;
endpackage

/* testbench/scale_frontend_model.sv */
/*
 load cell front end model: paced samples at a level set by the bench.
 assumes one clock, async active-low reset; gap shortened for run time.
*/
`timescale 1ns/1ps
`include "scale_weight_regs.svh"
module scale_frontend_model #(
    parameter int SMP_GAP = 8
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    input  wire logic signed [`WEIGHT_W-1:0] level,
    input  wire logic                        noisy,
    output logic                             sample_valid,
    output logic signed [`WEIGHT_W-1:0]      raw_weight
);
    logic [7:0] gap_q;
    logic       flip_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gap_q        <= 8'h00;
            flip_q       <= 1'b0;
            sample_valid <= 1'b0;
            raw_weight   <= '0;
        end else begin
            gap_q        <= (gap_q == 8'(SMP_GAP - 1)) ? 8'h00 : gap_q + 8'h01;
            sample_valid <= (gap_q == 8'h00);
            if (gap_q == 8'h00) begin
                flip_q     <= ~flip_q;
                raw_weight <= level + ((noisy && flip_q) ? 24'sh002000 : 24'sh000000);
            end else begin
                // unqualified between samples: alternates between the last sample and its inverse
                raw_weight <= ~raw_weight;
            end
        end
    end
endmodule // scale_frontend_model

/* testbench/scale_weight_processor_tb.sv */
/*
 self-checking bench for the weight processor with a front end model.
 assumes the design constants header and package are compiled first.
*/
`timescale 1ns/1ps
`include "scale_weight_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module scale_weight_processor_tb;
    typedef logic signed [`WEIGHT_W-1:0] w_t;
    logic clk_sys = 1'b0, rstn = 1'b0, noisy = 1'b0, print_req = 1'b0;
    logic motion_check = 1'b0, unipolar = 1'b0, sample_valid, print_go, weight_valid;
    w_t level = '0, preset_value = '0, raw_weight, gross_out, net_out, display_out;
    w_t auto_tare, preset_tare, g, v;
    logic [`WEIGHT_W-1:0] capacity = 24'h7FFFFF, resolution = 24'h000010;
    logic [`WEIGHT_W-1:0] motion_window = 24'h000040;
    scale_weight_pkg::cmd_t cmd = '0;
    scale_weight_pkg::tare_mode_t tare_mode = scale_weight_pkg::TARE_AUTO;
    scale_weight_pkg::status_t status;
    int error_cnt = 0, n_checks = 0;
    logic [31:0] seed_q = 32'h60A2;
    scale_frontend_model u_scale_frontend_model (.clk_sys(clk_sys), .rstn(rstn), .level(level),
        .noisy(noisy), .sample_valid(sample_valid), .raw_weight(raw_weight));
    scale_weight_processor u_scale_weight_processor (.clk_sys(clk_sys), .rstn(rstn),
        .sample_valid(sample_valid), .raw_weight(raw_weight), .cmd(cmd),
        .preset_value(preset_value), .print_req(print_req), .tare_mode(tare_mode),
        .track_mode(scale_weight_pkg::TRACK_OFF), .motion_check(motion_check),
        .unipolar(unipolar), .setpoint_armed(1'b0), .bandwidth(4'h0), .capacity(capacity),
        .resolution(resolution), .motion_window(motion_window), .filter_window(24'h000100),
        .no_motion_delay(16'h0004), .track_rate_steps(8'h01), .gross_out(gross_out),
        .net_out(net_out), .display_out(display_out), .auto_tare(auto_tare),
        .preset_tare(preset_tare), .status(status), .print_go(print_go),
        .weight_valid(weight_valid));
    function automatic logic [31:0] rnd();
        seed_q = seed_q ^ (seed_q << 13);
        seed_q = seed_q ^ (seed_q >> 17);
        seed_q = seed_q ^ (seed_q << 5);
        return seed_q;
    endfunction
    function automatic w_t net_of(input w_t gr, input w_t t1, input w_t t2);
        return gr - t1 - t2;
    endfunction
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one-hot code in field order tare, zero, gross_net, preset_wr
    task automatic pulse(input logic [3:0] c);
        @(posedge clk_sys);
        cmd <= scale_weight_pkg::cmd_t'(c);
        @(posedge clk_sys);
        cmd <= '0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    // filter settles in tens of samples; motion hold adds a few more
    task automatic settle();
        repeat (1500) @(posedge clk_sys);
        for (int i = 0; i < 4000 && status.motion !== 1'b0; i++) @(posedge clk_sys);
        #1;
    endtask
    initial forever #12.5 clk_sys = ~clk_sys;
    initial begin
        #1000000;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        resolution <= 24'h000008 + 24'(rnd() & 32'hF);
        v = 24'sh000100 + w_t'(rnd() & 32'hFFF);
        preset_value <= v;
        settle();
        @(posedge clk_sys iff sample_valid);
        #1;
        `CHK("weight_valid", 1'b1, weight_valid)
        `CHK("preset_tare", 24'sh0, preset_tare)
        pulse(4'h1);
        `CHK("preset_tare", 24'sh0, preset_tare)
        pulse(4'h2);
        `CHK("net_shown", 1'b0, status.net_shown)
        @(posedge clk_sys);
        level <= 24'sh001000 + w_t'(rnd() & 32'hFFFF);
        settle();
        g = gross_out;
        pulse(4'h8);
        `CHK("auto_tare", g, auto_tare)
        `CHK("net_shown", 1'b1, status.net_shown)
        `CHK("net_out", net_of(gross_out, auto_tare, '0), net_out)
        `CHK("display_out", net_out, display_out)
        @(posedge clk_sys);
        tare_mode <= scale_weight_pkg::TARE_PRESET;
        pulse(4'h1);
        `CHK("preset_tare", v, preset_tare)
        `CHK("net_out", net_of(gross_out, preset_tare, '0), net_out)
        @(posedge clk_sys);
        tare_mode <= scale_weight_pkg::TARE_BOTH;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK("net_out", net_of(gross_out, auto_tare, preset_tare), net_out)
        g = auto_tare;
        @(posedge clk_sys);
        noisy <= 1'b1;
        motion_check <= 1'b1;
        for (int i = 0; i < 3000 && status.motion !== 1'b1; i++) @(posedge clk_sys);
        #1;
        `CHK("motion", 1'b1, status.motion)
        @(posedge clk_sys);
        print_req <= 1'b1;
        @(posedge clk_sys);
        print_req <= 1'b0;
        pulse(4'h8);
        `CHK("print_go", 1'b0, print_go)
        `CHK("auto_tare", g, auto_tare)
        pulse(4'h4);
        `CHK("auto_tare", g, auto_tare)
        @(posedge clk_sys);
        noisy <= 1'b0;
        // print_go stands one cycle only: look just after each edge
        for (int i = 0; i < 6000 && print_go !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHK("motion", 1'b0, status.motion)
        `CHK("print_go", 1'b1, print_go)
        @(posedge clk_sys);
        motion_check <= 1'b0;
        settle();
        pulse(4'h4);
        `CHK("auto_tare", 24'sh0, auto_tare)
        `CHK("gross_out", 24'sh0, gross_out)
        `CHK("good_zero", 1'b1, status.good_zero)
        @(posedge clk_sys);
        unipolar <= 1'b1;
        level <= level - 24'sh001388;
        settle();
        pulse(4'h8);
        `CHK("gross_sign", 1'b1, gross_out[`WEIGHT_W-1])
        `CHK("auto_tare", 24'sh0, auto_tare)
        end_sim();
    end
endmodule // scale_weight_processor_tb
